// ---- core/csf_pkg.sv ----
/*
  Constants and types for the controller status flag generator: time-base
  figures, reset values, mode switch and operating mode encodings.
  Assumes a single 100 MHz system clock and a synchronous active-high reset.
*/
package csf_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS = 25;
  localparam int NS_PER_MS = 1000000;
  localparam int TICK_CYCLES = (TICK_MS * NS_PER_MS) / CLK_PERIOD_NS;

  localparam int MINUTE_HALF_MS = 30000;
  localparam int SECOND_HALF_MS = 500;
  localparam int TENTH_HALF_MS = 50;
  localparam int TWENTIETH_HALF_MS = 25;

  localparam int SQ_COUNT = 4;
  localparam int SQ_MINUTE = 0;
  localparam int SQ_SECOND = 1;
  localparam int SQ_TENTH = 2;
  localparam int SQ_TWENTIETH = 3;
  localparam int SQ_HALF_TICKS [SQ_COUNT] = '{
    MINUTE_HALF_MS / TICK_MS,
    SECOND_HALF_MS / TICK_MS,
    TENTH_HALF_MS / TICK_MS,
    TWENTIETH_HALF_MS / TICK_MS
  };

  //////////////////////////////////////////////////////////////////////////
  // Levels and reset values
  localparam logic FLAG_ON = 1'b1;
  localparam logic FLAG_OFF = 1'b0;
  localparam logic SQ_START_LEVEL = 1'b1;
  localparam logic FIRST_SCAN_RST = 1'b1;
  localparam logic ALT_SCAN_RST = 1'b0;
  localparam logic STICKY_RST = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Battery configuration word
  localparam int CFG_WORD_W = 16;
  localparam logic [CFG_WORD_W-1:0] BATTERY_OFF_CODE_DEF = 16'h0001;

  //////////////////////////////////////////////////////////////////////////
  // Mode switch and operating mode
  typedef enum logic [1:0] {
    CSF_SW_STOP,
    CSF_SW_TERM,
    CSF_SW_RUN
  } csf_switch_e;

  typedef enum logic [2:0] {
    CSF_MODE_PROGRAM,
    CSF_MODE_RUN,
    CSF_MODE_TEST_RUN,
    CSF_MODE_TEST_HOLD,
    CSF_MODE_TEST_PROGRAM
  } csf_mode_e;

endpackage : csf_pkg

// ---- core/csf_square_gen.sv ----
/*
  One square-wave time-base flag: toggles after a fixed number of shared
  base ticks. Assumes the tick is a one-cycle pulse from the common divider.
*/
`timescale 1ns/1ps
module csf_square_gen #(
  parameter int HALF_TICKS = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  output logic square_flag
);

  localparam int CW = $clog2(HALF_TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);

  logic [CW-1:0] half_cnt_reg;

  generate
    if (HALF_TICKS < 1) begin : g_bad_half
      $error("csf_square_gen: HALF_TICKS must be at least 1");
    end
  endgenerate

  // Counts ticks within the current half period
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      half_cnt_reg <= '0;
    end else if (tick) begin
      if (half_cnt_reg == LAST) begin
        half_cnt_reg <= '0;
      end else begin
        half_cnt_reg <= half_cnt_reg + CW'(1);
      end
    end
  end

  // Starts high at reset and flips at every half-period boundary
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      square_flag <= csf_pkg::SQ_START_LEVEL;
    end else if (tick && half_cnt_reg == LAST) begin
      square_flag <= ~square_flag;
    end
  end

endmodule : csf_square_gen

// ---- core/csf_status_flags.sv ----
/*
  Controller status flag generator: scan flags, square-wave time bases and
  mode, instruction and battery flags offered to the user program.
  Assumes scan_end and the instruction strobes are one-cycle pulses
  synchronous to ref_clk, and the mode inputs are stable levels.
*/
`timescale 1ns/1ps
module csf_status_flags #(
  parameter int TICK_CYCLES = csf_pkg::TICK_CYCLES,
  parameter logic [csf_pkg::CFG_WORD_W-1:0] BATTERY_OFF_CODE =
    csf_pkg::BATTERY_OFF_CODE_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scan_end,
  input csf_pkg::csf_switch_e mode_switch,
  input csf_pkg::csf_mode_e cpu_mode,
  input wire logic stop_instruction,
  input wire logic break_instruction,
  input wire logic interrupt_enable_instruction,
  input wire logic interrupt_disable_instruction,
  input wire logic [csf_pkg::CFG_WORD_W-1:0] battery_cfg_word,
  output logic first_scan_flag,
  output logic always_on_flag,
  output logic always_off_flag,
  output logic minute_square_flag,
  output logic second_square_flag,
  output logic tenth_second_square_flag,
  output logic twentieth_second_square_flag,
  output logic alternate_scan_flag,
  output logic forced_run_flag,
  output logic terminal_run_flag,
  output logic test_run_flag,
  output logic test_hold_flag,
  output logic test_program_flag,
  output logic terminal_program_flag,
  output logic switch_stop_flag,
  output logic instruction_stop_flag,
  output logic break_flag,
  output logic interrupt_enabled_flag,
  output logic battery_disabled_flag
);

  localparam int DW = $clog2(TICK_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("csf_status_flags: TICK_CYCLES must be at least 2");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Common divider for all time-base flags

  logic [DW-1:0] div_cnt_reg;
  logic base_tick;
  logic [csf_pkg::SQ_COUNT-1:0] sq_flags;

  assign base_tick = (div_cnt_reg == DIV_LAST);

  // Free running, independent of scan timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt_reg <= '0;
    end else if (base_tick) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + DW'(1);
    end
  end

  generate
    for (genvar i = 0; i < csf_pkg::SQ_COUNT; i++) begin : g_sq
      csf_square_gen #(
        .HALF_TICKS(csf_pkg::SQ_HALF_TICKS[i])
      ) u_sq (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(base_tick),
        .square_flag(sq_flags[i])
      );
    end
  endgenerate

  assign minute_square_flag = sq_flags[csf_pkg::SQ_MINUTE];
  assign second_square_flag = sq_flags[csf_pkg::SQ_SECOND];
  assign tenth_second_square_flag = sq_flags[csf_pkg::SQ_TENTH];
  assign twentieth_second_square_flag = sq_flags[csf_pkg::SQ_TWENTIETH];

  //////////////////////////////////////////////////////////////////////////
  // Constant contacts

  assign always_on_flag = csf_pkg::FLAG_ON;
  assign always_off_flag = csf_pkg::FLAG_OFF;

  //////////////////////////////////////////////////////////////////////////
  // Mode history

  csf_pkg::csf_mode_e prev_mode_reg;
  logic prog_to_run;
  logic enter_run;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_mode_reg <= csf_pkg::CSF_MODE_PROGRAM;
    end else begin
      prev_mode_reg <= cpu_mode;
    end
  end

  assign enter_run = (cpu_mode == csf_pkg::CSF_MODE_RUN) &&
                     (prev_mode_reg != csf_pkg::CSF_MODE_RUN);
  assign prog_to_run = enter_run &&
                       (prev_mode_reg == csf_pkg::CSF_MODE_PROGRAM);

  //////////////////////////////////////////////////////////////////////////
  // Scan flags

  // Armed at power-up and on program-to-run; a new arm beats scan_end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_scan_flag <= csf_pkg::FIRST_SCAN_RST;
    end else if (prog_to_run) begin
      first_scan_flag <= csf_pkg::FLAG_ON;
    end else if (scan_end) begin
      first_scan_flag <= csf_pkg::FLAG_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alternate_scan_flag <= csf_pkg::ALT_SCAN_RST;
    end else if (scan_end) begin
      alternate_scan_flag <= ~alternate_scan_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Switch and operating mode decode

  logic at_term;

  assign at_term = (mode_switch == csf_pkg::CSF_SW_TERM);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      forced_run_flag <= csf_pkg::FLAG_OFF;
      switch_stop_flag <= csf_pkg::FLAG_OFF;
    end else begin
      forced_run_flag <= (mode_switch == csf_pkg::CSF_SW_RUN);
      switch_stop_flag <= (mode_switch == csf_pkg::CSF_SW_STOP);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      terminal_run_flag <= csf_pkg::FLAG_OFF;
      test_run_flag <= csf_pkg::FLAG_OFF;
      test_hold_flag <= csf_pkg::FLAG_OFF;
      test_program_flag <= csf_pkg::FLAG_OFF;
      terminal_program_flag <= csf_pkg::FLAG_OFF;
    end else begin
      terminal_run_flag <= at_term &&
        (cpu_mode == csf_pkg::CSF_MODE_RUN);
      test_run_flag <= at_term &&
        (cpu_mode == csf_pkg::CSF_MODE_TEST_RUN);
      test_hold_flag <= at_term &&
        (cpu_mode == csf_pkg::CSF_MODE_TEST_HOLD);
      test_program_flag <= at_term &&
        (cpu_mode == csf_pkg::CSF_MODE_TEST_PROGRAM);
      terminal_program_flag <= at_term &&
        (cpu_mode == csf_pkg::CSF_MODE_PROGRAM);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Instruction and battery flags; for the instruction flags a set in the clearing cycle wins

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instruction_stop_flag <= csf_pkg::STICKY_RST;
    end else if (stop_instruction) begin
      instruction_stop_flag <= csf_pkg::FLAG_ON;
    end else if (enter_run) begin
      instruction_stop_flag <= csf_pkg::FLAG_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      break_flag <= csf_pkg::STICKY_RST;
    end else if (break_instruction) begin
      break_flag <= csf_pkg::FLAG_ON;
    end else if (enter_run) begin
      break_flag <= csf_pkg::FLAG_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interrupt_enabled_flag <= csf_pkg::STICKY_RST;
    end else if (interrupt_enable_instruction) begin
      interrupt_enabled_flag <= csf_pkg::FLAG_ON;
    end else if (interrupt_disable_instruction) begin
      interrupt_enabled_flag <= csf_pkg::FLAG_OFF;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      battery_disabled_flag <= csf_pkg::FLAG_OFF;
    end else begin
      battery_disabled_flag <= (battery_cfg_word == BATTERY_OFF_CODE);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_first_scan_arm: assert property (
    prog_to_run |=> first_scan_flag
  ) else $error("first scan flag not raised on program to run");

  a_first_scan_drop: assert property (
    scan_end && !prog_to_run |=> !first_scan_flag ##1
      (!first_scan_flag || $past(prog_to_run))
  ) else $error("first scan flag survived the scan boundary");

  a_const_contacts: assert property (
    always_on_flag && !always_off_flag
  ) else $error("constant contacts wrong");

  a_twentieth_toggle: assert property (
    base_tick |=> twentieth_second_square_flag !=
      $past(twentieth_second_square_flag)
  ) else $error("twentieth second flag missed its tick");

  a_square_steady: assert property (
    !base_tick |=> $stable(sq_flags)
  ) else $error("time base flag moved without a tick");

  a_tenth_pair: assert property (
    base_tick && !twentieth_second_square_flag
      |=> tenth_second_square_flag != $past(tenth_second_square_flag)
  ) else $error("tenth second flag out of phase");

  a_alt_toggle: assert property (
    scan_end |=> alternate_scan_flag != $past(alternate_scan_flag)
  ) else $error("alternate scan flag did not toggle");

  a_alt_hold: assert property (
    !scan_end |=> $stable(alternate_scan_flag)
  ) else $error("alternate scan flag moved between scans");

  a_forced_run: assert property (
    !rst |=> forced_run_flag == ($past(mode_switch) == csf_pkg::CSF_SW_RUN)
  ) else $error("forced run flag wrong");

  a_term_run: assert property (
    !rst |=> terminal_run_flag ==
      ($past(at_term) && $past(cpu_mode) == csf_pkg::CSF_MODE_RUN)
  ) else $error("terminal run flag wrong");

  a_term_onehot: assert property (
    $onehot0({terminal_run_flag, test_run_flag, test_hold_flag,
              test_program_flag, terminal_program_flag}) &&
    !(forced_run_flag && test_hold_flag)
  ) else $error("terminal mode flags overlap");

  a_switch_stop: assert property (
    !rst && mode_switch == csf_pkg::CSF_SW_STOP |=> switch_stop_flag &&
      !forced_run_flag && !terminal_program_flag
  ) else $error("switch stop flag wrong");

  a_stop_instr: assert property (
    stop_instruction |=> instruction_stop_flag
  ) else $error("instruction stop flag not set");

  a_break_clear: assert property (
    enter_run && !break_instruction |=> !break_flag
  ) else $error("break flag not cleared on run");

  a_break_hold: assert property (
    break_flag && !enter_run |=> break_flag
  ) else $error("break flag lost");

  a_int_enable: assert property (
    interrupt_enable_instruction |=> interrupt_enabled_flag
  ) else $error("interrupt enabled flag not set");

  a_battery: assert property (
    !rst ##1 $stable(battery_cfg_word) |->
      battery_disabled_flag == (battery_cfg_word == BATTERY_OFF_CODE)
  ) else $error("battery disabled flag wrong");

  c_first_scan_rerun: cover property (
    prog_to_run ##[1:20] scan_end
  );

  c_break_cycle: cover property (
    break_instruction ##[1:50] enter_run
  );

  c_tenth_flip: cover property (
    base_tick && tenth_second_square_flag ##1 !tenth_second_square_flag
  );

  c_term_test_hold: cover property (
    test_hold_flag ##[1:20] terminal_run_flag
  );

endmodule : csf_status_flags

// ---- verification/csf_scan_model.sv ----
/*
  Scan sequencer model: pulses the scan boundary strobe once every
  scan_gap cycles while enabled, and keeps it low otherwise.
  Assumes the bench clock and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module csf_scan_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scan_enable,
  input wire logic [3:0] scan_gap,
  output logic scan_end
);
  logic [3:0] gap_count_reg;

  // A gap of one gives back-to-back scan boundaries
  always_ff @(posedge ref_clk) begin
    if (rst || !scan_enable) begin
      gap_count_reg <= 4'h0;
      scan_end <= 1'b0;
    end else if (gap_count_reg >= scan_gap - 4'h1) begin
      gap_count_reg <= 4'h0;
      scan_end <= 1'b1;
    end else begin
      gap_count_reg <= gap_count_reg + 4'h1;
      scan_end <= 1'b0;
    end
  end
endmodule : csf_scan_model

// ---- verification/csf_status_flags_tb.sv ----
/*
  Self-checking bench for the status flag generator: a table of decode
  cases, then time base, scan, first-scan arm and sticky flag tests.
  Assumes csf_pkg, csf_status_flags and the scan sequencer model.
*/
`timescale 1ns/1ps
module csf_status_flags_tb;
  localparam int TICK = 4;
  typedef struct packed {
    logic [1:0] sw;
    logic [2:0] mode;
    logic [15:0] batt;
    logic [7:0] flags;
  } csf_row_s;
  // Switch codes stop/term/run are 0/1/2; modes follow the enum order
  localparam csf_row_s ROWS [11] = '{
    '{2'h2, 3'h1, 16'h0000, 8'h80},
    '{2'h2, 3'h3, 16'h0000, 8'h80},
    '{2'h1, 3'h1, 16'h0000, 8'h40},
    '{2'h1, 3'h2, 16'h0000, 8'h20},
    '{2'h1, 3'h3, 16'h0000, 8'h10},
    '{2'h1, 3'h4, 16'h0000, 8'h08},
    '{2'h1, 3'h0, 16'h0000, 8'h04},
    '{2'h0, 3'h1, 16'h0001, 8'h03},
    '{2'h0, 3'h0, 16'h0003, 8'h02},
    '{2'h1, 3'h1, 16'h0001, 8'h41},
    '{2'h3, 3'h1, 16'h0000, 8'h00}
  };

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scan_enable = 1'b0;
  logic [3:0] scan_gap = 4'h1;
  logic scan_end;
  csf_pkg::csf_switch_e mode_switch = csf_pkg::CSF_SW_STOP;
  csf_pkg::csf_mode_e cpu_mode = csf_pkg::CSF_MODE_PROGRAM;
  logic [3:0] strobes = 4'h0;
  logic [15:0] battery_cfg_word = 16'h0000;
  logic first_scan_flag, always_on_flag, always_off_flag;
  logic minute_square_flag, second_square_flag;
  logic tenth_second_square_flag, twentieth_second_square_flag;
  logic alternate_scan_flag, forced_run_flag, terminal_run_flag;
  logic test_run_flag, test_hold_flag, test_program_flag;
  logic terminal_program_flag, switch_stop_flag, instruction_stop_flag;
  logic break_flag, interrupt_enabled_flag, battery_disabled_flag;
  logic exp_first, exp_alt;
  int checks = 0;
  int failures = 0;

  always #5 ref_clk = ~ref_clk;

  csf_scan_model csf_scan_model_i (.ref_clk, .rst, .scan_enable,
    .scan_gap, .scan_end);

  csf_status_flags #(.TICK_CYCLES(TICK)) csf_status_flags_i (
    .ref_clk, .rst, .scan_end, .mode_switch, .cpu_mode,
    .stop_instruction(strobes[3]),
    .break_instruction(strobes[2]),
    .interrupt_enable_instruction(strobes[1]),
    .interrupt_disable_instruction(strobes[0]),
    .battery_cfg_word, .first_scan_flag, .always_on_flag,
    .always_off_flag, .minute_square_flag, .second_square_flag,
    .tenth_second_square_flag, .twentieth_second_square_flag,
    .alternate_scan_flag, .forced_run_flag, .terminal_run_flag,
    .test_run_flag, .test_hold_flag, .test_program_flag,
    .terminal_program_flag, .switch_stop_flag, .instruction_stop_flag,
    .break_flag, .interrupt_enabled_flag, .battery_disabled_flag);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Level of a square wave k cycles after reset release, starting high
  function automatic logic sq_level(input int k, input int half_ms);
    return ((k / ((half_ms / 25) * TICK)) % 2) == 0;
  endfunction : sq_level

  task automatic check_base(input int n);
    int k;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    exp_first = 1'b1;
    exp_alt = 1'b0;
    for (k = 0; k < n; k++) begin
      #1;
      if (k == 0) begin
        check("reset flags", 8'({first_scan_flag, alternate_scan_flag,
          instruction_stop_flag, break_flag, interrupt_enabled_flag}),
          8'h10);
      end
      check("square flags", 8'({minute_square_flag, second_square_flag,
        tenth_second_square_flag, twentieth_second_square_flag}),
        8'({sq_level(k, 30000), sq_level(k, 500), sq_level(k, 50),
        sq_level(k, 25)}));
      check("constant flags", 8'({always_on_flag, always_off_flag}),
        8'h02);
      @(posedge ref_clk);
    end
  endtask : check_base

  task automatic track(input int n, input logic en, input logic [3:0] gap);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge ref_clk);
      scan_enable <= en;
      scan_gap <= gap;
      #1;
      check("scan flags", 8'({first_scan_flag, alternate_scan_flag}),
        8'({exp_first, exp_alt}));
      if (scan_end === 1'b1) begin
        exp_alt = ~exp_alt;
        exp_first = 1'b0;
      end
    end
  endtask : track

  task automatic set_mode(input csf_pkg::csf_mode_e m);
    @(posedge ref_clk);
    cpu_mode <= m;
    @(posedge ref_clk);
    #1;
  endtask : set_mode

  task automatic pulse(input logic [3:0] v);
    @(posedge ref_clk);
    strobes <= v;
    @(posedge ref_clk);
    strobes <= 4'h0;
    #1;
  endtask : pulse

  function automatic logic [7:0] sticky();
    return 8'({instruction_stop_flag, break_flag, interrupt_enabled_flag});
  endfunction : sticky

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge ref_clk);
      mode_switch <= csf_pkg::csf_switch_e'(ROWS[i].sw);
      cpu_mode <= csf_pkg::csf_mode_e'(ROWS[i].mode);
      battery_cfg_word <= ROWS[i].batt;
      @(posedge ref_clk);
      #1;
      check("mode flags", {forced_run_flag, terminal_run_flag,
        test_run_flag, test_hold_flag, test_program_flag,
        terminal_program_flag, switch_stop_flag, battery_disabled_flag},
        ROWS[i].flags);
    end
    @(posedge ref_clk);
    cpu_mode <= csf_pkg::CSF_MODE_PROGRAM;
    check_base(9700);
    track(12, 1'b1, 4'h3);
    track(6, 1'b1, 4'h1);
    track(4, 1'b0, 4'h1);
    set_mode(csf_pkg::CSF_MODE_RUN);
    check("armed first scan", 8'(first_scan_flag), 8'h01);
    exp_first = 1'b1;
    track(6, 1'b1, 4'h2);
    track(4, 1'b0, 4'h2);
    pulse(4'hE);
    check("sticky set", sticky(), 8'h07);
    set_mode(csf_pkg::CSF_MODE_TEST_RUN);
    check("sticky held", sticky(), 8'h07);
    set_mode(csf_pkg::CSF_MODE_RUN);
    check("sticky on run", sticky(), 8'h01);
    check("unarmed first scan", 8'(first_scan_flag), 8'h00);
    pulse(4'h3);
    check("enable beats disable", sticky(), 8'h01);
    pulse(4'h1);
    check("interrupt disabled", sticky(), 8'h00);
    check_base(40);
    give_verdict();
  end
endmodule : csf_status_flags_tb
